// ### mrs_pkg.sv
/*
  Package for the motor drive run sequencer: sequencer states, option encodings,
  pipeline depths and widths shared by the drive end and the car-controller end.
  Assumes a single 100 MHz drive clock with synchronous active-low reset.
*/
package mrs_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int MRS_SPEED_W = 16;
  localparam int MRS_TORQUE_W = 16;
  localparam int MRS_SYNC_STAGES = 2;
  localparam int MRS_CLK_MHZ = 100;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [MRS_TORQUE_W-1:0] MRS_TORQUE_RST = 16'h0000;
  localparam logic [MRS_SPEED_W-1:0] MRS_SPEED_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Speed reference release source
  // ----------------------------------------------------------------
  localparam logic MRS_REL_REGULATOR = 1'b0;
  localparam logic MRS_REL_BRAKE = 1'b1;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MRS_IDLE,
    MRS_CONTACT_WAIT,
    MRS_RUNNING,
    MRS_RAMP_DOWN
  } mrs_state_t;

  // ----------------------------------------------------------------
  // Controller end states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MRS_C_IDLE,
    MRS_C_WAIT_READY,
    MRS_C_RUN,
    MRS_C_STOP,
    MRS_C_WAIT_ECHO
  } mrs_ctl_state_t;

endpackage : mrs_pkg

// ### mrs_link_if.sv
/*
  Interface carrying the logic inputs and outputs between the elevator car
  controller and the drive. Assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface mrs_link_if;
  import mrs_pkg::*;
  logic drivePermit;
  logic runRequest;
  logic directionSelect;
  logic [1:0] profileSelect;
  logic brakeOpen;
  logic pretorqueCapture;
  logic [MRS_TORQUE_W-1:0] pretorqueValue;
  logic [MRS_SPEED_W-1:0] speedCommand;
  logic contactorClosed;
  logic runReady;
  logic runEcho;
  logic faultOut;
  logic contactorClose;

  modport drive (
    input drivePermit, runRequest, directionSelect, profileSelect, brakeOpen,
    input pretorqueCapture, pretorqueValue, speedCommand, contactorClosed,
    output runReady, runEcho, faultOut, contactorClose
  );
  modport ctrl (
    output drivePermit, runRequest, directionSelect, profileSelect, brakeOpen,
    output pretorqueCapture, pretorqueValue, speedCommand, contactorClosed,
    input runReady, runEcho, faultOut, contactorClose
  );
endinterface : mrs_link_if
`default_nettype wire

// ### mrs_drive_end.sv
/*
  Drive end of the run sequencer: synchronises the controller's logic inputs,
  gates a run request on permit and readiness, echoes the run, optionally
  sequences the motor contactor, holds the echo through a torque ramp-down,
  captures a pre-torque value and releases the speed reference.
  Assumes the controller end drives the link on the same sys_clk domain or
  from pins; every input is therefore passed through two flip-flops.
*/
`timescale 1ns/1ps
`default_nettype none
module mrs_drive_end
  import mrs_pkg::*;
#(
  parameter int SPEED_W = MRS_SPEED_W,
  parameter int TORQUE_W = MRS_TORQUE_W
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  mrs_link_if.drive link,
  input wire logic softwareReady,
  input wire logic faultPresent,
  input wire logic contactorControlMode,
  input wire logic rampDownEnable,
  input wire logic ref_release_source,
  input wire logic regulatorRelease,
  input wire logic pretorqueUsed,
  input wire logic torqueAtZero,
  output logic runConfirm,
  output logic speedRefRelease,
  output logic rampActive,
  output logic signed [SPEED_W-1:0] speedCmdSigned,
  output logic [1:0] profileSelected,
  output logic pretorqueValid,
  output logic [TORQUE_W-1:0] pretorqueStored
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NBIT = 7;
  localparam int NWORD = SPEED_W + TORQUE_W;
  logic [NBIT-1:0] bitMeta, bitSync;
  logic [NWORD-1:0] wordMeta, wordSync;
  logic [NBIT-1:0] rawBits;
  logic [NWORD-1:0] rawWords;
  logic capturePrev;

  assign rawBits = {link.drivePermit, link.runRequest, link.directionSelect,
                    link.profileSelect, link.brakeOpen, link.pretorqueCapture};
  assign rawWords = {link.speedCommand, link.pretorqueValue};

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bitMeta <= '0;
      bitSync <= '0;
      wordMeta <= '0;
      wordSync <= '0;
      capturePrev <= 1'b0;
    end else if (clkEn) begin
      bitMeta <= rawBits;
      bitSync <= bitMeta;
      wordMeta <= rawWords;
      wordSync <= wordMeta;
      capturePrev <= bitSync[0];
    end
  end

  logic permitS, runS, dirS, brakeS, captureS, captureRise;
  logic [1:0] profileS;
  logic [SPEED_W-1:0] speedS;
  logic [TORQUE_W-1:0] pretorqueS;
  assign {permitS, runS, dirS, profileS, brakeS, captureS} = bitSync;
  assign {speedS, pretorqueS} = wordSync;
  assign captureRise = captureS && !capturePrev;

  // Contactor confirmation is a separate pin with its own synchroniser.
  logic confirmMeta, confirmS;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      confirmMeta <= 1'b0;
      confirmS <= 1'b0;
    end else if (clkEn) begin
      confirmMeta <= link.contactorClosed;
      confirmS <= confirmMeta;
    end
  end

  // ----------------------------------------------------------------
  // Run sequencer
  // ----------------------------------------------------------------
  mrs_state_t state, next_state;
  logic ready;
  logic runPrev, next_runPrev;
  logic echo, next_echo;
  logic closeOut, next_closeOut;
  logic confirm, next_confirm;
  logic [1:0] profile, next_profile;

  assign ready = softwareReady && !faultPresent;

  always_comb begin
    next_state = state;
    next_runPrev = runS;
    next_echo = echo;
    next_closeOut = closeOut;
    next_confirm = confirm;
    next_profile = profile;
    case (state)
      MRS_IDLE: begin
        next_echo = 1'b0;
        next_closeOut = 1'b0;
        next_confirm = 1'b0;
        // A request held before ready rose does not count; a fresh edge is needed.
        if (runS && !runPrev && ready && permitS) begin
          next_profile = profileS;
          next_echo = 1'b1;
          if (contactorControlMode) begin
            next_closeOut = 1'b1;
            next_state = MRS_CONTACT_WAIT;
          end else begin
            next_confirm = 1'b1;
            next_state = MRS_RUNNING;
          end
        end
      end
      MRS_CONTACT_WAIT: begin
        if (confirmS) begin
          next_confirm = 1'b1;
          next_state = MRS_RUNNING;
        end
        if (!runS) begin
          next_echo = 1'b0;
          next_closeOut = 1'b0;
          next_state = MRS_IDLE;
        end
      end
      MRS_RUNNING: begin
        if (!runS) begin
          if (rampDownEnable && !torqueAtZero) begin
            next_state = MRS_RAMP_DOWN;
          end else begin
            next_echo = 1'b0;
            next_confirm = 1'b0;
            next_closeOut = 1'b0;
            next_state = MRS_IDLE;
          end
        end
      end
      MRS_RAMP_DOWN: begin
        if (torqueAtZero) begin
          next_echo = 1'b0;
          next_confirm = 1'b0;
          next_closeOut = 1'b0;
          next_state = MRS_IDLE;
        end
      end
      default: begin
        next_state = MRS_IDLE;
      end
    endcase
    if (!permitS || faultPresent) begin
      next_state = MRS_IDLE;
      next_echo = 1'b0;
      next_confirm = 1'b0;
      next_closeOut = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= MRS_IDLE;
      runPrev <= 1'b0;
      echo <= 1'b0;
      closeOut <= 1'b0;
      confirm <= 1'b0;
      profile <= 2'h0;
    end else if (clkEn) begin
      state <= next_state;
      runPrev <= next_runPrev;
      echo <= next_echo;
      closeOut <= next_closeOut;
      confirm <= next_confirm;
      profile <= next_profile;
    end
  end

  // ----------------------------------------------------------------
  // Pre-torque capture and reference release
  // ----------------------------------------------------------------
  logic ptValid, next_ptValid;
  logic [TORQUE_W-1:0] ptValue, next_ptValue;
  logic refRel, next_refRel;
  logic signed [SPEED_W-1:0] speedOut, next_speedOut;
  logic readyQ, faultQ;

  always_comb begin
    next_ptValid = ptValid;
    next_ptValue = ptValue;
    if (regulatorRelease && pretorqueUsed && ptValid) begin
      next_ptValid = 1'b0;
      next_ptValue = MRS_TORQUE_RST;
    end
    if (captureRise) begin
      next_ptValid = 1'b1;
      next_ptValue = pretorqueS;
    end
    if (ref_release_source == MRS_REL_BRAKE) begin
      next_refRel = regulatorRelease && brakeS && confirm;
    end else begin
      next_refRel = regulatorRelease && confirm;
    end
    if (dirS) begin
      next_speedOut = SPEED_W'(-$signed(speedS));
    end else begin
      next_speedOut = $signed(speedS);
    end
    if (!next_refRel) begin
      next_speedOut = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ptValid <= 1'b0;
      ptValue <= MRS_TORQUE_RST;
      refRel <= 1'b0;
      speedOut <= '0;
      readyQ <= 1'b0;
      faultQ <= 1'b0;
    end else if (clkEn) begin
      ptValid <= next_ptValid;
      ptValue <= next_ptValue;
      refRel <= next_refRel;
      speedOut <= next_speedOut;
      readyQ <= ready;
      faultQ <= faultPresent;
    end
  end

  assign link.runReady = readyQ;
  assign link.faultOut = faultQ;
  assign link.runEcho = echo;
  assign link.contactorClose = closeOut;
  assign runConfirm = confirm;
  assign speedRefRelease = refRel;
  assign rampActive = (state == MRS_RAMP_DOWN);
  assign speedCmdSigned = speedOut;
  assign profileSelected = profile;
  assign pretorqueValid = ptValid;
  assign pretorqueStored = ptValue;

endmodule : mrs_drive_end
`default_nettype wire

// ### mrs_ctrl_end.sv
/*
  Car-controller end of the run sequencer: turns a user trip request into the
  ordered logic sequence toward the drive (selects with contactor, then capture
  with run, then brake) and releases it in the safe order at stop.
  Assumes the drive end samples every input through synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
module mrs_ctrl_end
  import mrs_pkg::*;
#(
  parameter int SPEED_W = MRS_SPEED_W,
  parameter int TORQUE_W = MRS_TORQUE_W
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  mrs_link_if.ctrl link,
  input wire logic safetyChainOk,
  input wire logic tripRequest,
  input wire logic tripDown,
  input wire logic [1:0] tripProfile,
  input wire logic [SPEED_W-1:0] tripSpeed,
  input wire logic [TORQUE_W-1:0] tripPretorque,
  input wire logic contactorFeedback,
  output logic tripActive,
  output logic driveFault
);

  mrs_ctl_state_t state, next_state;
  logic run, next_run;
  logic dir, next_dir;
  logic [1:0] prof, next_prof;
  logic brake, next_brake;
  logic cap, next_cap;
  logic contact, next_contact;
  logic [SPEED_W-1:0] spd, next_spd;
  logic [TORQUE_W-1:0] pt, next_pt;

  always_comb begin
    next_state = state;
    next_run = run;
    next_dir = dir;
    next_prof = prof;
    next_brake = brake;
    next_cap = cap;
    next_contact = contact;
    next_spd = spd;
    next_pt = pt;
    case (state)
      MRS_C_IDLE: begin
        if (tripRequest && safetyChainOk) begin
          next_dir = tripDown;
          next_prof = tripProfile;
          next_pt = tripPretorque;
          next_contact = 1'b1;
          next_state = MRS_C_WAIT_READY;
        end
      end
      MRS_C_WAIT_READY: begin
        if (link.runReady && contactorFeedback) begin
          next_cap = 1'b1;
          next_run = 1'b1;
          next_state = MRS_C_RUN;
        end
      end
      MRS_C_RUN: begin
        next_brake = 1'b1;
        if (brake) begin
          next_spd = tripSpeed;
        end
        if (!tripRequest) begin
          next_spd = '0;
          next_state = MRS_C_STOP;
        end
      end
      MRS_C_STOP: begin
        next_brake = 1'b0;
        if (!brake) begin
          next_run = 1'b0;
          next_cap = 1'b0;
          next_state = MRS_C_WAIT_ECHO;
        end
      end
      MRS_C_WAIT_ECHO: begin
        if (!link.runEcho) begin
          next_contact = 1'b0;
          next_state = MRS_C_IDLE;
        end
      end
      default: begin
        next_state = MRS_C_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= MRS_C_IDLE;
      run <= 1'b0;
      dir <= 1'b0;
      prof <= 2'h0;
      brake <= 1'b0;
      cap <= 1'b0;
      contact <= 1'b0;
      spd <= MRS_SPEED_RST;
      pt <= MRS_TORQUE_RST;
    end else if (clkEn) begin
      state <= next_state;
      run <= next_run;
      dir <= next_dir;
      prof <= next_prof;
      brake <= next_brake;
      cap <= next_cap;
      contact <= next_contact;
      spd <= next_spd;
      pt <= next_pt;
    end
  end

  assign link.drivePermit = safetyChainOk;
  assign link.runRequest = run;
  assign link.directionSelect = dir;
  assign link.profileSelect = prof;
  assign link.brakeOpen = brake;
  assign link.pretorqueCapture = cap;
  assign link.pretorqueValue = pt;
  assign link.speedCommand = spd;
  assign link.contactorClosed = contact;
  assign tripActive = (state != MRS_C_IDLE);
  assign driveFault = link.faultOut;

endmodule : mrs_ctrl_end
`default_nettype wire

// ### mrs_link_properties.sv
/*
  Checker for the link between the car-controller end and the drive end.
  Assumes it watches the interface signals on sys_clk with nrst active low.
*/
`timescale 1ns/1ps
`default_nettype none
module mrs_link_properties
  import mrs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic drivePermit,
  input wire logic runRequest,
  input wire logic directionSelect,
  input wire logic [1:0] profileSelect,
  input wire logic brakeOpen,
  input wire logic pretorqueCapture,
  input wire logic [MRS_SPEED_W-1:0] speedCommand,
  input wire logic contactorClosed,
  input wire logic runReady,
  input wire logic runEcho,
  input wire logic faultOut,
  input wire logic contactorClose
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_permit;
    !drivePermit [*3] |=> !runEcho && !contactorClose;
  endproperty
  a_permit: assert property (p_permit) else $error("echo without permit");
  property p_echo_rise;
    $rose(runEcho) |-> $past(runRequest, 3) && !$past(runRequest, 4);
  endproperty
  a_echo_rise: assert property (p_echo_rise) else $error("echo rise late");
  property p_echo_fall;
    $fell(runRequest) |-> ##3 !runEcho;
  endproperty
  a_echo_fall: assert property (p_echo_fall) else $error("echo fall late");
  property p_contact_first;
    runRequest |-> contactorClosed;
  endproperty
  a_contact_first: assert property (p_contact_first) else $error("run without contactor");
  property p_contact_held;
    $fell(contactorClosed) |-> !runEcho;
  endproperty
  a_contact_held: assert property (p_contact_held) else $error("contactor open early");
  property p_selects;
    $rose(runRequest) |-> $stable(directionSelect) && $stable(profileSelect);
  endproperty
  a_selects: assert property (p_selects) else $error("selects moved at run");
  property p_brake_speed;
    speedCommand != 16'h0000 |-> brakeOpen;
  endproperty
  a_brake_speed: assert property (p_brake_speed) else $error("speed with brake set");
  property p_brake_stop;
    $fell(runRequest) |-> !brakeOpen;
  endproperty
  a_brake_stop: assert property (p_brake_stop) else $error("run dropped, brake open");
  property p_capture;
    $rose(runRequest) |-> pretorqueCapture;
  endproperty
  a_capture: assert property (p_capture) else $error("capture after run");
  property p_fault;
    faultOut |-> !runReady && !runEcho && !contactorClose;
  endproperty
  a_fault: assert property (p_fault) else $error("fault with run active");
  c_run: cover property ($rose(runEcho));
  c_stop: cover property ($fell(runEcho));
  c_fault: cover property ($rose(faultOut));
endmodule : mrs_link_properties
`default_nettype wire

// ### test_motor_drive_run_sequencer.sv
/*
  Testbench: a controller end faces a drive end across one link; a second
  drive end is driven directly through a second link. Assumes mrs_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module test_motor_drive_run_sequencer;
  import mrs_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clkEn = 1'b1;
  logic softwareReady = 1'b0, faultPresent = 1'b0, contactorMode = 1'b0, rampDownEnable = 1'b0;
  logic refRelSource = 1'b0, regulatorRelease = 1'b0, pretorqueUsed = 1'b0, torqueAtZero = 1'b0;
  logic safetyChainOk = 1'b0, tripRequest = 1'b0, contactorFeedback = 1'b1, tripDown = 1'b1;
  logic [1:0] tripProfile = 2'h2;
  logic [15:0] tripSpeed = 16'h0100, tripPretorque = 16'h0abc;
  logic tripActive, driveFault, runConfirm, speedRefRelease, rampActive, pretorqueValid;
  logic [1:0] profileSelected;
  logic signed [15:0] speedCmdSigned;
  logic [15:0] pretorqueStored;
  int fails = 0, checked = 0, cycles = 0;
  mrs_link_if link ();
  mrs_link_if l2 ();
  always #5 sys_clk = ~sys_clk;
  mrs_ctrl_end mrs_ctrl_end_inst (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .link(link),
    .safetyChainOk(safetyChainOk), .tripRequest(tripRequest), .tripDown(tripDown),
    .tripProfile(tripProfile), .tripSpeed(tripSpeed), .tripPretorque(tripPretorque),
    .contactorFeedback(contactorFeedback), .tripActive(tripActive), .driveFault(driveFault));
  mrs_drive_end mrs_drive_end_inst (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
    .link(link), .softwareReady(softwareReady), .faultPresent(faultPresent),
    .contactorControlMode(contactorMode), .rampDownEnable(rampDownEnable),
    .ref_release_source(refRelSource), .regulatorRelease(regulatorRelease),
    .pretorqueUsed(pretorqueUsed), .torqueAtZero(torqueAtZero), .runConfirm(),
    .speedRefRelease(), .rampActive(), .speedCmdSigned(), .profileSelected(),
    .pretorqueValid(), .pretorqueStored());
  mrs_drive_end mrs_drive_end_inst_b (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
    .link(l2), .softwareReady(softwareReady), .faultPresent(faultPresent),
    .contactorControlMode(contactorMode), .rampDownEnable(rampDownEnable),
    .ref_release_source(refRelSource), .regulatorRelease(regulatorRelease),
    .pretorqueUsed(pretorqueUsed), .torqueAtZero(torqueAtZero), .runConfirm(runConfirm),
    .speedRefRelease(speedRefRelease), .rampActive(rampActive),
    .speedCmdSigned(speedCmdSigned), .profileSelected(profileSelected),
    .pretorqueValid(pretorqueValid), .pretorqueStored(pretorqueStored));
  mrs_link_properties mrs_link_properties_inst (.sys_clk(sys_clk), .nrst(nrst),
    .drivePermit(link.drivePermit), .runRequest(link.runRequest),
    .directionSelect(link.directionSelect), .profileSelect(link.profileSelect),
    .brakeOpen(link.brakeOpen), .pretorqueCapture(link.pretorqueCapture),
    .speedCommand(link.speedCommand), .contactorClosed(link.contactorClosed),
    .runReady(link.runReady), .runEcho(link.runEcho), .faultOut(link.faultOut),
    .contactorClose(link.contactorClose));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // The run is cut short well past the expected length of the tests.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {l2.drivePermit, l2.runRequest, l2.directionSelect, l2.brakeOpen} = 4'h8;
    l2.pretorqueCapture = 1'b0;
    l2.profileSelect = 2'h1;
    l2.pretorqueValue = 16'h1234;
    l2.speedCommand = 16'h0005;
    l2.contactorClosed = 1'b1;
    step(8);
    nrst = 1'b1;
    step(1);
    chk("ready", 16'(l2.runReady), 16'h0000);
    chk("fault", 16'(l2.faultOut), 16'h0000);
    l2.runRequest = 1'b1;
    step(5);
    chk("echo", 16'(l2.runEcho), 16'h0000);
    softwareReady = 1'b1;
    step(3);
    chk("ready", 16'(l2.runReady), 16'h0001);
    chk("echo", 16'(l2.runEcho), 16'h0000);
    l2.runRequest = 1'b0;
    step(4);
    l2.directionSelect = 1'b1;
    l2.runRequest = 1'b1;
    step(2);
    chk("echo", 16'(l2.runEcho), 16'h0000);
    step(1);
    chk("echo", 16'(l2.runEcho), 16'h0001);
    chk("confirm", 16'(runConfirm), 16'h0001);
    chk("close", 16'(l2.contactorClose), 16'h0000);
    regulatorRelease = 1'b1;
    step(3);
    chk("release", 16'(speedRefRelease), 16'h0001);
    chk("speed", speedCmdSigned, 16'hfffb);
    chk("profile", 16'(profileSelected), 16'h0001);
    $display("test accept done");
    l2.pretorqueCapture = 1'b1;
    step(4);
    l2.pretorqueValue = 16'h5678;
    step(4);
    chk("ptvalid", 16'(pretorqueValid), 16'h0001);
    chk("ptstored", pretorqueStored, 16'h1234);
    pretorqueUsed = 1'b1;
    step(2);
    chk("ptvalid", 16'(pretorqueValid), 16'h0000);
    chk("ptstored", pretorqueStored, 16'h0000);
    pretorqueUsed = 1'b0;
    $display("test pretorque done");
    rampDownEnable = 1'b1;
    l2.runRequest = 1'b0;
    step(6);
    chk("echo", 16'(l2.runEcho), 16'h0001);
    chk("ramp", 16'(rampActive), 16'h0001);
    torqueAtZero = 1'b1;
    step(2);
    chk("echo", 16'(l2.runEcho), 16'h0000);
    chk("ramp", 16'(rampActive), 16'h0000);
    rampDownEnable = 1'b0;
    torqueAtZero = 1'b0;
    $display("test ramp done");
    l2.runRequest = 1'b1;
    step(4);
    chk("echo", 16'(l2.runEcho), 16'h0001);
    faultPresent = 1'b1;
    step(2);
    chk("fault", 16'(l2.faultOut), 16'h0001);
    chk("drive fault", 16'(driveFault), 16'h0001);
    chk("ready", 16'(l2.runReady), 16'h0000);
    chk("confirm", 16'(runConfirm), 16'h0000);
    chk("echo", 16'(l2.runEcho), 16'h0000);
    faultPresent = 1'b0;
    l2.runRequest = 1'b0;
    step(3);
    chk("fault", 16'(l2.faultOut), 16'h0000);
    l2.runRequest = 1'b1;
    step(4);
    chk("echo", 16'(l2.runEcho), 16'h0001);
    l2.drivePermit = 1'b0;
    step(4);
    chk("echo", 16'(l2.runEcho), 16'h0000);
    l2.runRequest = 1'b0;
    l2.drivePermit = 1'b1;
    l2.directionSelect = 1'b0;
    $display("test abort done");
    step(4);
    contactorMode = 1'b1;
    l2.contactorClosed = 1'b0;
    l2.runRequest = 1'b1;
    step(4);
    chk("close", 16'(l2.contactorClose), 16'h0001);
    chk("confirm", 16'(runConfirm), 16'h0000);
    l2.contactorClosed = 1'b1;
    step(4);
    chk("confirm", 16'(runConfirm), 16'h0001);
    refRelSource = 1'b1;
    step(3);
    chk("release", 16'(speedRefRelease), 16'h0000);
    chk("speed", speedCmdSigned, 16'h0000);
    l2.brakeOpen = 1'b1;
    step(4);
    chk("release", 16'(speedRefRelease), 16'h0001);
    chk("speed", speedCmdSigned, 16'h0005);
    l2.runRequest = 1'b0;
    contactorMode = 1'b0;
    $display("test contactor done");
    step(4);
    safetyChainOk = 1'b1;
    tripRequest = 1'b1;
    for (int i = 0; i < 60 && link.runEcho !== 1'b1; i++) step(1);
    chk("echo", 16'(link.runEcho), 16'h0001);
    chk("permit", 16'(link.drivePermit), 16'h0001);
    chk("dir", 16'(link.directionSelect), 16'h0001);
    chk("trip", 16'(tripActive), 16'h0001);
    step(10);
    tripRequest = 1'b0;
    for (int i = 0; i < 80 && link.runEcho !== 1'b0; i++) step(1);
    chk("echo", 16'(link.runEcho), 16'h0000);
    step(10);
    chk("contact", 16'(link.contactorClosed), 16'h0000);
    chk("trip", 16'(tripActive), 16'h0000);
    $display("test trip done");
    tally_and_finish();
  end
endmodule : test_motor_drive_run_sequencer
`default_nettype wire
